// ==== rte_pkg.sv ====
// constants and types shared by the read-only transponder encoder
package rte_pkg;

  // ----------------------------------------------------------------
  // identification word and memory walk
  // ----------------------------------------------------------------
  localparam int unsigned ID_BITS    = 64;
  localparam int unsigned ADDR_W     = 6;
  localparam logic [5:0]  ADDR_FIRST = 6'h3F;
  localparam logic [5:0]  ADDR_STEP  = 6'h01;

  // ----------------------------------------------------------------
  // bit buffer
  // ----------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_W     = 2;
  localparam int unsigned FLD_DATA   = 0;
  localparam int unsigned FLD_FIRST  = 1;

  // ----------------------------------------------------------------
  // carrier clocks per bit and asymmetric on-phase trim
  // ----------------------------------------------------------------
  localparam logic [6:0] DIV_8K  = 7'h10;
  localparam logic [6:0] DIV_4K  = 7'h20;
  localparam logic [6:0] DIV_2K  = 7'h40;
  localparam logic [3:0] SKEW_8K = 4'h0;
  localparam logic [3:0] SKEW_4K = 4'h4;
  localparam logic [3:0] SKEW_2K = 4'h8;

  // ----------------------------------------------------------------
  // mask options and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RTE_MAN  = 2'h0,
    RTE_BIPH = 2'h1,
    RTE_PSK  = 2'h2
  } rte_coding_e;

  typedef enum logic [1:0] {
    RTE_2K = 2'h0,
    RTE_4K = 2'h1,
    RTE_8K = 2'h2
  } rte_rate_e;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_REQ  = 2'h1,
    RD_CAP  = 2'h3
  } rte_rd_e;

endpackage

// ==== rte_encoder.sv ====
// bit buffer and encoder core of the read-only transponder
//
// Functional notes
// - carrier is the only clock for everything
// - bit period 16, 32 or 64 carriers
// - identification word sent over and over
// - memory read periodically after reset release
// - switch toggles only after reset released
// - reset forces switch off, unloaded
// - coding and rate fixed per variant
// - manchester: one rises mid-bit, zero falls
// - biphase: toggle at start, zero toggles mid
// - rising drive delayed, asymmetric modulation
// - on trimmed 8 or 4 clocks, none at 8 kbaud
// - psk modulates at half carrier, no trim
// - psk bit lasts 16 carriers
// - psk zero inverts phase, one keeps
// - identification word read only here
`timescale 1ns/1ps

// ------------------------------------------------------------------
// synchronous fifo
// ------------------------------------------------------------------
module rte_fifo #(
  parameter int unsigned WIDTH = rte_pkg::FIFO_W,
  parameter int unsigned DEPTH = rte_pkg::FIFO_DEPTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [PW:0]      count_q;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_q != (PW+1)'(DEPTH));
  assign o_out_valid = (count_q != '0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem[rd_ptr_q];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + PW'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + PW'(1);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + (PW+1)'(1);
    end else if (pop && !push) begin
      count_q <= count_q - (PW+1)'(1);
    end
  end

endmodule // rte_fifo

// ------------------------------------------------------------------
// encoder top
// ------------------------------------------------------------------
module rte_encoder #(
  parameter rte_pkg::rte_coding_e CODING = rte_pkg::RTE_MAN,
  parameter rte_pkg::rte_rate_e   RATE   = rte_pkg::RTE_4K
) (
  input  wire logic       I_CLOCK,
  input  wire logic       I_RESET,
  output logic            O_NVM_RD,
  output logic [5:0]      O_NVM_ADDR,
  input  wire logic       I_NVM_DATA,
  output logic            O_MOD,
  output logic            O_TX_BIT,
  output logic            O_BIT_STROBE,
  output logic            O_WORD_START
);

  // ----------------------------------------------------------------
  // mask option decode
  // ----------------------------------------------------------------
  function automatic logic [6:0] rte_div(input rte_pkg::rte_coding_e c, input rte_pkg::rte_rate_e r);
    if (c == rte_pkg::RTE_PSK || r == rte_pkg::RTE_8K) begin
      return rte_pkg::DIV_8K;
    end else if (r == rte_pkg::RTE_4K) begin
      return rte_pkg::DIV_4K;
    end
    return rte_pkg::DIV_2K;
  endfunction

  function automatic logic [3:0] rte_skew(input rte_pkg::rte_coding_e c, input rte_pkg::rte_rate_e r);
    if (c == rte_pkg::RTE_PSK || r == rte_pkg::RTE_8K) begin
      return rte_pkg::SKEW_8K;
    end else if (r == rte_pkg::RTE_4K) begin
      return rte_pkg::SKEW_4K;
    end
    return rte_pkg::SKEW_2K;
  endfunction

  // options are elaboration constants, never run-time inputs
  localparam logic [6:0] DIV  = rte_div(CODING, RATE);
  localparam logic [6:0] LAST = 7'(DIV - 7'h01);
  localparam logic [6:0] MID  = 7'((DIV >> 1) - 7'h01);
  localparam logic [3:0] SKEW = rte_skew(CODING, RATE);
  localparam logic       IS_PSK  = (CODING == rte_pkg::RTE_PSK);
  localparam logic       IS_BIPH = (CODING == rte_pkg::RTE_BIPH);

  // ----------------------------------------------------------------
  // memory reader
  // ----------------------------------------------------------------
  rte_pkg::rte_rd_e rd_state_q;
  logic [5:0]       addr_q;
  logic             req_first_q;
  logic             in_valid;
  logic             in_ready;
  logic [1:0]       in_data;
  logic             out_valid;
  logic             out_ready;
  logic [1:0]       out_data;

  // read-only walk, no write path exists
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      rd_state_q <= rte_pkg::RD_IDLE;
    end else begin
      case (rd_state_q)
        rte_pkg::RD_IDLE: begin
          rd_state_q <= rte_pkg::RD_REQ;
        end
        rte_pkg::RD_REQ: begin
          if (in_ready) begin
            rd_state_q <= rte_pkg::RD_CAP;
          end
        end
        rte_pkg::RD_CAP: begin
          rd_state_q <= rte_pkg::RD_REQ;
        end
        default: begin
          rd_state_q <= rte_pkg::RD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      addr_q      <= rte_pkg::ADDR_FIRST;
      req_first_q <= 1'b0;
    end else if (rd_state_q == rte_pkg::RD_REQ && in_ready) begin
      req_first_q <= (addr_q == rte_pkg::ADDR_FIRST);
      addr_q      <= addr_q - rte_pkg::ADDR_STEP;
    end
  end

  assign O_NVM_RD   = (rd_state_q == rte_pkg::RD_REQ) && in_ready;
  assign O_NVM_ADDR = addr_q;
  assign in_valid   = (rd_state_q == rte_pkg::RD_CAP);
  assign in_data    = {req_first_q, I_NVM_DATA};

  rte_fifo #(
    .WIDTH (rte_pkg::FIFO_W),
    .DEPTH (rte_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (I_CLOCK),
    .i_rst       (I_RESET),
    .i_in_valid  (in_valid),
    .o_in_ready  (in_ready),
    .i_in_data   (in_data),
    .o_out_valid (out_valid),
    .i_out_ready (out_ready),
    .o_out_data  (out_data)
  );

  // ----------------------------------------------------------------
  // bit timing
  // ----------------------------------------------------------------
  logic [6:0] bit_cnt_q;
  logic       at_last;
  logic       at_mid;
  logic       next_bit;

  assign at_last   = (bit_cnt_q == LAST);
  assign at_mid    = (bit_cnt_q == MID);
  assign out_ready = at_last;
  assign next_bit  = out_data[rte_pkg::FLD_DATA];

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      bit_cnt_q <= '0;
    end else begin
      bit_cnt_q <= at_last ? 7'h00 : bit_cnt_q + 7'h01;
    end
  end

  logic cur_bit_q;
  logic have_bit_q;
  logic strobe_q;
  logic word_q;

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      cur_bit_q  <= 1'b0;
      have_bit_q <= 1'b0;
      strobe_q   <= 1'b0;
      word_q     <= 1'b0;
    end else begin
      strobe_q <= at_last && out_valid;
      word_q   <= at_last && out_valid && out_data[rte_pkg::FLD_FIRST];
      if (at_last) begin
        have_bit_q <= out_valid;
        cur_bit_q  <= out_valid && next_bit;
      end
    end
  end

  // ----------------------------------------------------------------
  // symmetric level for manchester and biphase
  // ----------------------------------------------------------------
  logic lvl_q;

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      lvl_q <= 1'b0;
    end else if (at_last) begin
      if (!out_valid) begin
        lvl_q <= 1'b0;
      end else if (IS_BIPH) begin
        lvl_q <= !lvl_q;
      end else begin
        lvl_q <= !next_bit;
      end
    end else if (at_mid && have_bit_q) begin
      if (IS_BIPH) begin
        lvl_q <= cur_bit_q ? lvl_q : !lvl_q;
      end else begin
        lvl_q <= cur_bit_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // asymmetric trim: on phase starts late
  // ----------------------------------------------------------------
  logic [3:0] on_cnt_q;

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      on_cnt_q <= '0;
    end else if (!lvl_q) begin
      on_cnt_q <= '0;
    end else if (on_cnt_q != SKEW) begin
      on_cnt_q <= on_cnt_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // phase shift keying
  // ----------------------------------------------------------------
  logic half_q;
  logic psk_ph_q;

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      half_q <= 1'b0;
    end else begin
      half_q <= !half_q;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      psk_ph_q <= 1'b0;
    end else if (at_last && out_valid && !next_bit) begin
      psk_ph_q <= !psk_ph_q;
    end
  end

  // ----------------------------------------------------------------
  // modulation switch drive
  // ----------------------------------------------------------------
  logic mod_q;
  logic mod_d;

  always_comb begin
    if (IS_PSK) begin
      mod_d = have_bit_q && (half_q ^ psk_ph_q);
    end else begin
      mod_d = have_bit_q && lvl_q && (on_cnt_q == SKEW);
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      mod_q <= 1'b0;
    end else begin
      mod_q <= mod_d;
    end
  end

  assign O_MOD        = mod_q;
  assign O_TX_BIT     = cur_bit_q;
  assign O_BIT_STROBE = strobe_q;
  assign O_WORD_START = word_q;

endmodule // rte_encoder

// ==== rte_encoder_assertions.sv ====
// port assertions for the transponder encoder
`timescale 1ns/1ps
module rte_encoder_chk #(
  parameter rte_pkg::rte_coding_e CODING = rte_pkg::RTE_MAN,
  parameter rte_pkg::rte_rate_e   RATE   = rte_pkg::RTE_4K
) (
  input wire logic       I_CLOCK,
  input wire logic       I_RESET,
  input wire logic       O_NVM_RD,
  input wire logic [5:0] O_NVM_ADDR,
  input wire logic       I_NVM_DATA,
  input wire logic       O_MOD,
  input wire logic       O_TX_BIT,
  input wire logic       O_BIT_STROBE,
  input wire logic       O_WORD_START
);
  localparam bit PSK  = (CODING == rte_pkg::RTE_PSK);
  localparam bit MAN  = (CODING == rte_pkg::RTE_MAN);
  localparam int DIV  = PSK ? 16 : (RATE == rte_pkg::RTE_2K) ? 64 : 32;
  localparam int SKW  = PSK ? 0 : (RATE == rte_pkg::RTE_2K) ? 8 : 4;
  localparam int HALF = DIV / 2;
  localparam int RISE = HALF + SKW;
  localparam int Q3   = DIV * 3 / 4;
  localparam int H1   = HALF - 1;
  localparam bit BIPH = (CODING == rte_pkg::RTE_BIPH);
  logic [6:0] cnt_q;
  logic [6:0] bits_q;
  logic       seen_q;
  logic       wseen_q;
  // ----------------------------------------------------------------
  // cycle and bit counters
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      cnt_q  <= 7'h00;
      seen_q <= 1'b0;
    end else begin
      cnt_q  <= O_BIT_STROBE ? 7'h00 : cnt_q + 7'h01;
      seen_q <= seen_q | O_BIT_STROBE;
    end
  end
  always_ff @(posedge I_CLOCK or posedge I_RESET) begin
    if (I_RESET) begin
      bits_q  <= 7'h00;
      wseen_q <= 1'b0;
    end else begin
      bits_q  <= O_WORD_START ? 7'h00 : bits_q + {6'h00, O_BIT_STROBE};
      wseen_q <= wseen_q | O_WORD_START;
    end
  end
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);
  chk_rd_spacing: assert property (O_NVM_RD |=> !O_NVM_RD)
    else $error("read strobes too close");
  chk_addr_walk: assert property (1'b1 |=>
    O_NVM_ADDR == ($past(O_NVM_RD) ? $past(O_NVM_ADDR) - 6'h01 : $past(O_NVM_ADDR)))
    else $error("address walk broken");
  chk_reset_off: assert property ($past(I_RESET) |-> !O_MOD && !O_BIT_STROBE)
    else $error("switch not off after reset");
  chk_bit_period: assert property (seen_q && O_BIT_STROBE |-> cnt_q == DIV - 1)
    else $error("bit period wrong");
  chk_word_align: assert property (O_WORD_START |-> O_BIT_STROBE)
    else $error("word start off a bit boundary");
  chk_word_len: assert property (wseen_q && O_WORD_START |-> bits_q == 7'h3F)
    else $error("word length wrong");
  chk_man_level: assert property (MAN && O_BIT_STROBE |-> ##Q3 O_MOD == O_TX_BIT)
    else $error("second half level wrong");
  chk_on_skew: assert property (MAN && O_BIT_STROBE && O_TX_BIT |-> ##RISE !O_MOD ##1 O_MOD)
    else $error("on edge not trimmed");
  chk_off_edge: assert property (MAN && O_BIT_STROBE && !O_TX_BIT |-> ##HALF O_MOD ##1 !O_MOD)
    else $error("off edge moved");
  chk_psk_toggle: assert property (PSK && $past(seen_q) && !$past(O_BIT_STROBE) |-> O_MOD != $past(O_MOD))
    else $error("half carrier toggle missing");
  chk_psk_phase: assert property (PSK && seen_q && O_BIT_STROBE |=> (O_MOD != $past(O_MOD)) == $past(O_TX_BIT))
    else $error("phase step wrong");
  chk_bi_start: assert property (BIPH && O_BIT_STROBE |-> ##H1 O_MOD != $past(O_MOD, H1))
    else $error("bit start toggle missing");
  cov_word: cover property (O_WORD_START);
  cov_one: cover property (O_BIT_STROBE && O_TX_BIT);
  cov_zero: cover property (O_BIT_STROBE && !O_TX_BIT);
  cov_psk_zero: cover property (PSK && O_BIT_STROBE && !O_TX_BIT);
endmodule // rte_encoder_chk

bind rte_encoder rte_encoder_chk #(.CODING(CODING), .RATE(RATE)) chk_u (
  .I_CLOCK      (I_CLOCK),
  .I_RESET      (I_RESET),
  .O_NVM_RD     (O_NVM_RD),
  .O_NVM_ADDR   (O_NVM_ADDR),
  .I_NVM_DATA   (I_NVM_DATA),
  .O_MOD        (O_MOD),
  .O_TX_BIT     (O_TX_BIT),
  .O_BIT_STROBE (O_BIT_STROBE),
  .O_WORD_START (O_WORD_START)
);

// ==== rte_nvm_model.sv ====
// identification memory model, one-cycle read latency
`timescale 1ns/1ps
module rte_nvm_model #(
  parameter logic [63:0] WORD = 64'h0
) (
  input  wire logic       i_clk,
  input  wire logic       i_rd,
  input  wire logic [5:0] i_addr,
  output logic            o_data
);
  initial o_data = 1'b0;
  // fixed word; bit scrambles outside its valid cycle
  always @(posedge i_clk) begin
    if (i_rd) begin
      o_data <= WORD[i_addr];
    end else begin
      o_data <= ~o_data;
    end
  end
endmodule // rte_nvm_model

// ==== test_ro_transponder_encoder.sv ====
// testbench for the read-only transponder encoder
`timescale 1ns/1ps
module test_ro_transponder_encoder;
  localparam logic [63:0] WORD = 64'hA5C30F961E78D24B;
  logic       I_CLOCK;
  logic       I_RESET;
  logic       O_NVM_RD;
  logic [5:0] O_NVM_ADDR;
  logic       I_NVM_DATA;
  logic       O_MOD;
  logic       O_TX_BIT;
  logic       O_BIT_STROBE;
  logic       O_WORD_START;
  int         bad_count = 0;
  int         n_compared = 0;
  int         cycles = 0;
  logic       bi_mod;
  logic       bi_tx_bit;
  logic       bi_strobe;
  logic       bi_rd;
  logic [5:0] bi_addr;
  logic       bi_data;
  logic       psk_mod;
  logic       psk_tx_bit;
  logic       psk_strobe;
  logic       psk_rd;
  logic [5:0] psk_addr;
  logic       psk_data;
  logic [2:0] stb;

  rte_encoder #(.CODING(rte_pkg::RTE_MAN), .RATE(rte_pkg::RTE_4K)) dut_u (
    .I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .O_NVM_RD(O_NVM_RD), .O_NVM_ADDR(O_NVM_ADDR),
    .I_NVM_DATA(I_NVM_DATA), .O_MOD(O_MOD), .O_TX_BIT(O_TX_BIT),
    .O_BIT_STROBE(O_BIT_STROBE), .O_WORD_START(O_WORD_START));
  rte_nvm_model #(.WORD(WORD)) nvm_u (
    .i_clk(I_CLOCK), .i_rd(O_NVM_RD), .i_addr(O_NVM_ADDR), .o_data(I_NVM_DATA));
  // biphase 2 kbaud and psk variants run beside the manchester one
  rte_encoder #(.CODING(rte_pkg::RTE_BIPH), .RATE(rte_pkg::RTE_2K)) dut_bi_u (
    .I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .O_NVM_RD(bi_rd), .O_NVM_ADDR(bi_addr),
    .I_NVM_DATA(bi_data), .O_MOD(bi_mod), .O_TX_BIT(bi_tx_bit),
    .O_BIT_STROBE(bi_strobe), .O_WORD_START());
  rte_nvm_model #(.WORD(WORD)) bi_nvm_u (
    .i_clk(I_CLOCK), .i_rd(bi_rd), .i_addr(bi_addr), .o_data(bi_data));
  rte_encoder #(.CODING(rte_pkg::RTE_PSK), .RATE(rte_pkg::RTE_8K)) dut_psk_u (
    .I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .O_NVM_RD(psk_rd), .O_NVM_ADDR(psk_addr),
    .I_NVM_DATA(psk_data), .O_MOD(psk_mod), .O_TX_BIT(psk_tx_bit),
    .O_BIT_STROBE(psk_strobe), .O_WORD_START());
  rte_nvm_model #(.WORD(WORD)) psk_nvm_u (
    .i_clk(I_CLOCK), .i_rd(psk_rd), .i_addr(psk_addr), .o_data(psk_data));
  assign stb = {psk_strobe, bi_strobe, O_BIT_STROBE};

  // carrier from the reader, no commands sent
  initial begin
    I_CLOCK = 1'b0;
    forever #12.5 I_CLOCK = ~I_CLOCK;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) begin
      @(posedge I_CLOCK);
      #1;
    end
  endtask
  task automatic wait_strobe(input int sel, output int k);
    k = 0;
    while (stb[sel] !== 1'b1 && k < 200) begin
      step(1);
      k++;
    end
  endtask
  task automatic summarize();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge I_CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_word_order();
    logic [63:0] got;
    int          k;
    k = 0;
    while (O_WORD_START !== 1'b1 && k < 2200) begin
      step(1);
      k++;
    end
    for (int i = 63; i >= 0; i--) begin
      got[i] = O_TX_BIT;
      step(1);
      wait_strobe(0, k);
      check(k, 31);
    end
    check(got, WORD);
    check(O_WORD_START, 1'b1);
  endtask
  task automatic t_manchester();
    logic b;
    int   k;
    for (int i = 0; i < 16; i++) begin
      b = O_TX_BIT;
      step(12);
      check(O_MOD, !b);
      step(4);
      check(O_MOD, !b);
      step(1);
      check(O_MOD, 1'b0);
      step(3);
      check(O_MOD, 1'b0);
      step(1);
      check(O_MOD, b);
      step(1);
      wait_strobe(0, k);
      check(k, 10);
    end
  endtask
  task automatic t_biphase();
    logic b;
    logic l;
    int   k;
    wait_strobe(1, k);
    for (int i = 0; i < 8; i++) begin
      b = bi_tx_bit;
      l = !bi_mod;
      step(8);
      check(bi_mod, 1'b0);
      step(1);
      check(bi_mod, l);
      step(31);
      check(bi_mod, b & l);
      step(1);
      check(bi_mod, b ? l : !l);
      wait_strobe(1, k);
      check(k, 23);
    end
  endtask
  task automatic t_psk();
    logic b;
    logic m;
    int   k;
    wait_strobe(2, k);
    for (int i = 0; i < 16; i++) begin
      b = psk_tx_bit;
      for (int j = 0; j < 16; j++) begin
        m = psk_mod;
        step(1);
        check(psk_mod, (j == 0 && !b) ? m : !m);
      end
      check(psk_strobe, 1'b1);
    end
  endtask
  task automatic t_midrun_reset();
    logic m;
    int   k;
    step(100);
    I_RESET = 1'b1;
    step(3);
    check({O_MOD, O_BIT_STROBE, O_NVM_RD, O_NVM_ADDR}, {3'b000, 6'h3F});
    I_RESET = 1'b0;
    m = 1'b0;
    for (k = 0; k < 40 && O_BIT_STROBE !== 1'b1; k++) begin
      m = m | O_MOD;
      step(1);
    end
    check(m, 1'b0);
    check({O_WORD_START, O_TX_BIT}, {1'b1, WORD[63]});
  endtask

  initial begin
    I_RESET = 1'b1;
    step(3);
    check({O_MOD, O_BIT_STROBE, O_NVM_RD, O_NVM_ADDR}, {3'b000, 6'h3F});
    I_RESET = 1'b0;
    t_word_order();
    t_manchester();
    t_biphase();
    t_psk();
    t_midrun_reset();
    t_word_order();
    summarize();
  end
endmodule // test_ro_transponder_encoder
